// File: rtl/pti_timer.sv
// Notes on behaviour
// - Register A sets the PWM period
// - Register B sets the output change point
// - Register C sets wait change point
// - Register D buffers B or holds the capture count
// - Control one write drives initial level
// - Five sources merge into one request
// - Request when flag and enable both set
// - Request drops when flag or enable clears
// - Further events keep request at one
// - Acknowledge leaves flags; software clears them
// - Clear beats coincident counter write
// - Readback after write may be old
// - Capture copies counter four cycles after the pin rises, without filter
//
// Local design decisions: the placing of the registers and register access over APB.
module pti_timer (
	input  wire logic        clk,        // 50 MHz peripheral clock
	input  wire logic        reset_n,    // Async reset, active low
	input  wire logic        psel,       // APB select
	input  wire logic        penable,    // APB access phase
	input  wire logic        pwrite,     // APB write
	input  wire logic [7:0]  paddr,      // APB byte address
	input  wire logic [31:0] pwdata,     // APB write data
	input  wire logic [3:0]  pstrb,      // APB byte strobes
	output logic      [31:0] prdata,     // APB read data
	output logic             pready,     // APB ready
	output logic             pslverr,    // APB error
	input  wire logic        captureIn,  // Capture pin, channel D
	input  wire logic        irqAck,     // Interrupt acknowledge pulse
	output logic             pwmOut,     // PWM output pin level
	output logic             pwmOutEn,   // PWM pin output enable
	output logic             irqRequest, // Request flag to controller
	output logic      [2:0]  irqPriority // Request priority level
);
	// Whole block state in one record, registered in one place
	typedef struct packed {
		logic [15:0] counter;  // Main counter
		logic [3:0]  mode;     // Timer mode register
		logic [5:0]  ctrl1;    // First timer control
		logic [2:0]  ctrl2;    // Second timer control
		logic [4:0]  status;   // Status flags
		logic [4:0]  readOne;  // Flag was read as one
		logic [4:0]  irqEn;    // Interrupt enables
		logic [2:0]  prio;     // Priority field
		logic [15:0] cmpA;     // Period compare
		logic [15:0] cmpB;     // Change point compare
		logic [15:0] cmpC;     // Wait point compare
		logic [15:0] cmpD;     // Buffered compare
		logic        pwm;      // Output level
		logic        pwmEn;    // Output enable
		logic        irq;      // Request flag
		logic [31:0] rdata;    // Read data
		logic        ready;    // Ready
		logic        err;      // Error
	} pti_state_s;
	pti_state_s cur;
	pti_state_s next_cur;

	// Decode and event nets, all on the same clock
	// None of these leaves the block, so glitches here stay harmless
	logic        tick;      // Count source pulse
	logic        capEdge;   // Capture edge pulse
	logic        run;       // Counting enabled
	logic        wrAccess;  // APB write in access phase
	logic        rdAccess;  // APB read in access phase
	logic        hit;       // Address mapped
	logic        matchA;    // Counter equals period
	logic        clrNow;    // Clear on period this cycle
	logic [15:0] wdat;      // Low half write data
	logic [4:0]  events;    // Hardware flag sets
	logic        initLevel; // Initial output level

	// Counting follows the run bit of the mode register
	assign run       = cur.mode[pti_pkg::MODE_RUN_BIT];
	// Access phase before ready is the one edge that commits a transfer
	// Gating with ready keeps a held request from acting twice
	assign wrAccess  = psel & penable & pwrite & ~cur.ready;
	assign rdAccess  = psel & penable & ~pwrite & ~cur.ready;
	// Only the low half carries data; upper bits are ignored
	assign wdat      = pwdata[15:0];
	// Level the pin returns to at period end and on stop
	assign initLevel = cur.ctrl1[pti_pkg::CTRL1_INIT_BIT];

	// Count source divider
	// Divider restarts at every start, so the first tick is a full step away
	pti_prescaler u_pre (
		.clk     (clk),
		.reset_n (reset_n),
		.run     (run),
		.srcSel  (cur.ctrl1[pti_pkg::CTRL1_SRC_LSB +: 3]),
		.tick    (tick)
	);

	// Capture pin synchroniser
	// Three flops add latency to a capture; the price of a safe pin crossing
	pti_capture_sync u_cap (
		.clk      (clk),
		.reset_n  (reset_n),
		.pinIn    (captureIn),
		.filterOn (cur.ctrl2[pti_pkg::CTRL2_FILT_BIT]),
		.edgeSeen (capEdge)
	);

	// Address decode
	// Only aligned words inside the map are claimed; the rest get an error
	// Byte lanes are not checked here
	always_comb begin
		case (paddr)
			pti_pkg::OFS_COUNTER, pti_pkg::OFS_MODE, pti_pkg::OFS_CTRL1,
			pti_pkg::OFS_CTRL2, pti_pkg::OFS_STATUS, pti_pkg::OFS_IRQEN,
			pti_pkg::OFS_IRQCTL, pti_pkg::OFS_CMP_A, pti_pkg::OFS_CMP_B,
			pti_pkg::OFS_CMP_C, pti_pkg::OFS_CMP_D: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// Period match seen by every compare user
	assign matchA = (cur.counter == cur.cmpA);
	// Clear on period needs a tick, so it only fires while counting
	assign clrNow = tick & matchA & cur.ctrl1[pti_pkg::CTRL1_CLR_BIT];

	// Hardware events for the status flags
	// Each source pulses for one cycle; the flag itself is sticky
	// Overflow is suppressed when the clear on period already wraps
	always_comb begin
		events = 5'h00;
		events[pti_pkg::ST_MATCH_A] = tick & matchA;
		events[pti_pkg::ST_MATCH_B] = tick & (cur.counter == cur.cmpB);
		events[pti_pkg::ST_MATCH_C] = tick & (cur.counter == cur.cmpC);
		events[pti_pkg::ST_MATCH_D] = capEdge & cur.ctrl2[pti_pkg::CTRL2_CAPEN_BIT];
		events[pti_pkg::ST_OVF]     = tick & (&cur.counter) & ~clrNow;
	end

	// Next-state logic: bus, counter, PWM, flags, request
	always_comb begin
		next_cur = cur;
		// Bus answer lines default to idle; they stand one cycle only
		next_cur.ready = 1'b0;
		next_cur.err = 1'b0;

		// Counter advance; period clear wins over a coincident write
		// Counter wraps from all ones to zero and flags overflow
		if (tick) begin
			next_cur.counter = cur.counter + 16'h0001;
		end
		// Software write needs both low byte lanes; a partial write is dropped
		if (wrAccess && hit && paddr == pti_pkg::OFS_COUNTER && pstrb[1:0] == 2'h3) begin
			next_cur.counter = wdat;
		end
		// A write landing on the wrap edge is lost, as software must expect
		// clear wins write
		if (clrNow) begin
			next_cur.counter = pti_pkg::RST_COUNTER;
		end

		// Compare matches steer the pin only in two-compare PWM mode
		// period from A
		if (tick && matchA && cur.mode[pti_pkg::MODE_PWM2_BIT]) begin
			// Period end: back to initial level
			next_cur.pwm = initLevel;
			// Period end also loads the buffered change point
			// D buffers B
			if (cur.mode[pti_pkg::MODE_BUFD_BIT]) begin
				next_cur.cmpB = cur.cmpD;
			end
			// Stop is honoured only in PWM mode, where the period is defined
			// Stop at period match, output to initial level
			if (cur.ctrl2[pti_pkg::CTRL2_STOP_BIT]) begin
				next_cur.mode[pti_pkg::MODE_RUN_BIT] = 1'b0;
			end
		end else if (tick && cur.mode[pti_pkg::MODE_PWM2_BIT]) begin
			// C takes priority over B should both ever match together
			// wait point C
			if (!cur.mode[pti_pkg::MODE_BUFC_BIT] && cur.counter == cur.cmpC) begin
				next_cur.pwm = ~initLevel;
			end else if (cur.counter == cur.cmpB) begin
				next_cur.pwm = initLevel;
			end
		end

		// A bus write to D in the same cycle wins over the capture
		// capture copy
		if (events[pti_pkg::ST_MATCH_D]) begin
			next_cur.cmpD = cur.counter;
		end

		// Register writes take effect in the access cycle
		// Unmapped writes are dropped; the error is raised further down
		if (wrAccess && hit) begin
			case (paddr)
				pti_pkg::OFS_MODE: begin
					// Run bit and buffer selects are taken as a whole nibble
					next_cur.mode = pwdata[3:0];
					// Stopping the count returns the pin to its initial level
					if (!pwdata[pti_pkg::MODE_RUN_BIT]) begin
						next_cur.pwm = initLevel;
					end
				end
				pti_pkg::OFS_CTRL1: begin
					next_cur.ctrl1 = pwdata[5:0];
					next_cur.pwm = pwdata[pti_pkg::CTRL1_INIT_BIT];
					// Pin enable follows the output select at once
					next_cur.pwmEn = pwdata[pti_pkg::CTRL1_OUTEN_BIT];
				end
				// Plain stores for the remaining registers
				pti_pkg::OFS_CTRL2:  next_cur.ctrl2 = pwdata[2:0];
				pti_pkg::OFS_IRQEN:  next_cur.irqEn = pwdata[4:0];
				pti_pkg::OFS_IRQCTL: next_cur.prio  = pwdata[3:1];
				pti_pkg::OFS_CMP_A:  next_cur.cmpA  = wdat;
				pti_pkg::OFS_CMP_B:  next_cur.cmpB  = wdat;
				pti_pkg::OFS_CMP_C:  next_cur.cmpC  = wdat;
				pti_pkg::OFS_CMP_D:  next_cur.cmpD  = wdat;
				default: begin
					// Status is handled below, counter above
				end
			endcase
		end

		// Only flags seen as one by an earlier read can be cleared
		// zero after read clears
		if (wrAccess && paddr == pti_pkg::OFS_STATUS) begin
			next_cur.status = cur.status & ~(cur.readOne & ~pwdata[4:0]);
			next_cur.readOne = cur.readOne & pwdata[4:0];
		end
		// Remember which flags a status read showed as one
		if (rdAccess && paddr == pti_pkg::OFS_STATUS) begin
			next_cur.readOne = cur.status;
		end
		// Set wins over a clear in the same cycle
		// A lost event would leave the handler blind to its source
		next_cur.status = next_cur.status | events;

		// Request is a plain function of flags and enables, never latched
		// A pending request survives new events without a glitch
		// ack keeps flags
		// Acknowledge is ignored here; only software clears status
		// five sources merged
		next_cur.irq = |(next_cur.status & next_cur.irqEn);

		// Read mux, sampled into the answer register
		// Reads see the value after any earlier write has settled
		// reads registered values
		if (rdAccess) begin
			case (paddr)
				// Unused upper bits read as zero
				pti_pkg::OFS_COUNTER: next_cur.rdata = {16'h0000, cur.counter};
				pti_pkg::OFS_MODE:    next_cur.rdata = {28'h0000000, cur.mode};
				pti_pkg::OFS_CTRL1:   next_cur.rdata = {26'h0000000, cur.ctrl1};
				pti_pkg::OFS_CTRL2:   next_cur.rdata = {29'h00000000, cur.ctrl2};
				pti_pkg::OFS_STATUS:  next_cur.rdata = {27'h0000000, cur.status};
				pti_pkg::OFS_IRQEN:   next_cur.rdata = {27'h0000000, cur.irqEn};
				// Request flag sits at bit 0 below the priority
				pti_pkg::OFS_IRQCTL:  next_cur.rdata = {28'h0000000, cur.prio, cur.irq};
				pti_pkg::OFS_CMP_A:   next_cur.rdata = {16'h0000, cur.cmpA};
				pti_pkg::OFS_CMP_B:   next_cur.rdata = {16'h0000, cur.cmpB};
				pti_pkg::OFS_CMP_C:   next_cur.rdata = {16'h0000, cur.cmpC};
				pti_pkg::OFS_CMP_D:   next_cur.rdata = {16'h0000, cur.cmpD};
				default:              next_cur.rdata = 32'h00000000;
			endcase
		end

		// One wait state; unmapped addresses answer with an error
		// Ready is a registered pulse, so the master sees exactly one wait state
		if (psel && penable && !cur.ready) begin
			next_cur.ready = 1'b1;
			next_cur.err = ~hit;
		end
	end

	// State register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// All but the compare registers start at zero, the pin level included
			// Compare registers wake at all ones, away from the reset count
			cur <= '0;
			cur.cmpA <= pti_pkg::RST_CMP;
			cur.cmpB <= pti_pkg::RST_CMP;
			cur.cmpC <= pti_pkg::RST_CMP;
			cur.cmpD <= pti_pkg::RST_CMP;
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs straight from flip-flops
	// No decode glitch can reach a pin or the bus this way
	assign prdata      = cur.rdata;
	assign pready      = cur.ready;
	assign pslverr     = cur.err;
	assign pwmOut      = cur.pwm;
	assign pwmOutEn    = cur.pwmEn;
	assign irqRequest  = cur.irq;
	assign irqPriority = cur.prio;
endmodule

// File: rtl/pti_pkg.sv
package pti_pkg;
	// Register byte offsets on the APB bus
	localparam logic [7:0] OFS_COUNTER   = 8'h00; // Main counter
	localparam logic [7:0] OFS_MODE      = 8'h04; // Timer mode register
	localparam logic [7:0] OFS_CTRL1     = 8'h08; // First timer control
	localparam logic [7:0] OFS_CTRL2     = 8'h0c; // Second timer control
	localparam logic [7:0] OFS_STATUS    = 8'h10; // Status flags
	localparam logic [7:0] OFS_IRQEN     = 8'h14; // Interrupt enables
	localparam logic [7:0] OFS_IRQCTL    = 8'h18; // Request flag and priority
	localparam logic [7:0] OFS_CMP_A     = 8'h1c; // Period compare
	localparam logic [7:0] OFS_CMP_B     = 8'h20; // Change point compare
	localparam logic [7:0] OFS_CMP_C     = 8'h24; // Wait point compare
	localparam logic [7:0] OFS_CMP_D     = 8'h28; // Buffered compare
	// Mode register fields
	localparam int MODE_RUN_BIT    = 0;            // Count run
	localparam int MODE_BUFC_BIT   = 1;            // Register C buffer select
	localparam int MODE_BUFD_BIT   = 2;            // Register D buffer select
	localparam int MODE_PWM2_BIT   = 3;            // Two-compare PWM mode enable
	// First control fields
	localparam int CTRL1_INIT_BIT  = 0;            // Initial output level
	localparam int CTRL1_SRC_LSB   = 1;            // Count source select, 3 bits
	localparam int CTRL1_CLR_BIT   = 4;            // Clear on period match
	localparam int CTRL1_OUTEN_BIT = 5;            // Pin is waveform output
	// Second control fields
	localparam int CTRL2_STOP_BIT  = 0;            // Stop at period match
	localparam int CTRL2_FILT_BIT  = 1;            // Capture digital filter
	localparam int CTRL2_CAPEN_BIT = 2;            // Capture enable on channel D
	// Status flag positions
	localparam int ST_MATCH_A      = 0;            // Compare match A
	localparam int ST_MATCH_B      = 1;            // Compare match B
	localparam int ST_MATCH_C      = 2;            // Compare match C
	localparam int ST_MATCH_D      = 3;            // Capture on channel D
	localparam int ST_OVF          = 4;            // Counter overflow
	localparam int NUM_SRC         = 5;            // Request sources
	// Reset values
	localparam logic [15:0] RST_CMP     = 16'hffff; // Compare registers
	localparam logic [15:0] RST_COUNTER = 16'h0000; // Counter and clear value
	// Capture filter samples, highest source code
	localparam int FILT_SAMPLES    = 3;            // Agreeing samples with filter
	localparam logic [2:0] SRC_MAX = 3'h4;         // Highest valid source code
endpackage

// File: rtl/pti_prescaler.sv
// Count-source tick generator: f1 divided by 1,2,4,8,32
module pti_prescaler (
	input  wire logic       clk,     // Peripheral base clock
	input  wire logic       reset_n, // Async reset, active low
	input  wire logic       run,     // Counting enabled
	input  wire logic [2:0] srcSel,  // Count source select
	output logic            tick     // One-cycle count pulse
);
	typedef struct packed {
		logic [4:0] div; // Divider, held at zero while stopped
	} pti_pre_s;
	pti_pre_s cur;
	pti_pre_s next_cur;

	// Divider runs only while counting so each start is aligned
	always_comb begin
		next_cur = cur;
		next_cur.div = run ? cur.div + 5'h01 : 5'h00;
	end

	// Tick when the chosen divider bits are all ones
	always_comb begin
		case (srcSel)
			3'h0: tick = run;
			3'h1: tick = run & cur.div[0];
			3'h2: tick = run & (&cur.div[1:0]);
			3'h3: tick = run & (&cur.div[2:0]);
			default: tick = run & (&cur.div);
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
endmodule

// File: rtl/pti_capture_sync.sv
// Three-stage pin synchroniser with edge detect and optional filter
module pti_capture_sync (
	input  wire logic clk,      // Timer clock
	input  wire logic reset_n,  // Async reset, active low
	input  wire logic pinIn,    // Raw capture pin
	input  wire logic filterOn, // Digital filter enable
	output logic      edgeSeen  // One-cycle rising edge pulse
);
	typedef struct packed {
		logic [2:0] sync;  // Sync chain, bit 0 is first stage
		logic       level; // Accepted level
		logic [1:0] agree; // Filter agreement count
	} pti_cap_s;
	pti_cap_s cur;
	pti_cap_s next_cur;
	logic     stable;

	// First stage only feeds the second; stages two and three vote
	always_comb begin
		next_cur = cur;
		next_cur.sync = {cur.sync[1:0], pinIn};
		stable = (cur.sync[1] == cur.sync[2]);
		edgeSeen = 1'b0;
		if (!filterOn) begin
			if (stable && cur.sync[2] != cur.level) begin
				next_cur.level = cur.sync[2];
				edgeSeen = cur.sync[2];
			end
		end else if (!stable || cur.sync[2] == cur.level) begin
			// Filter restarts on any disagreement
			next_cur.agree = 2'h0;
		end else if (cur.agree == 2'(pti_pkg::FILT_SAMPLES - 1)) begin
			next_cur.level = cur.sync[2];
			next_cur.agree = 2'h0;
			edgeSeen = cur.sync[2];
		end else begin
			next_cur.agree = cur.agree + 2'h1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
endmodule

// File: verification/pti_timer_props.sv
module pti_timer_props (
	input wire logic        clk,        // Clock
	input wire logic        reset_n,    // Reset
	input wire logic        psel,       // Select
	input wire logic        penable,    // Access
	input wire logic        pwrite,     // Write
	input wire logic [7:0]  paddr,      // Address
	input wire logic [31:0] pwdata,     // Wdata
	input wire logic [3:0]  pstrb,      // Strobes
	input wire logic [31:0] prdata,     // Rdata
	input wire logic        pready,     // Ready
	input wire logic        pslverr,    // Error
	input wire logic        captureIn,  // Capture
	input wire logic        irqAck,     // Ack
	input wire logic        pwmOut,     // Pin
	input wire logic        pwmOutEn,   // Pin enable
	input wire logic        irqRequest, // Request
	input wire logic [2:0]  irqPriority // Priority
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wrDone;  // Write taken this edge
	logic stopped; // Counting is off
	assign wrDone = psel && penable && pready && pwrite && pstrb[0];
	// Only a mode write can start the count; one with pstrb[0] low is missed and leaves stopped wrongly set
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stopped <= 1'b1;
		end else if (wrDone && paddr == pti_pkg::OFS_MODE) begin
			stopped <= !pwdata[pti_pkg::MODE_RUN_BIT];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("ready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
	a_err_unmapped: assert property (psel && penable && !pready && paddr[1:0] == 2'h0
		|=> pslverr == (paddr > pti_pkg::OFS_CMP_D)) else $error("error flag wrong");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000) else $error("upper read");
	a_req_held: assert property (irqRequest && !psel && !$past(psel) |=> irqRequest)
		else $error("request lost");
	a_ack_keeps: assert property (irqAck && irqRequest && !psel && !$past(psel) |=> irqRequest)
		else $error("ack cleared request");
	a_req_drop: assert property (wrDone && paddr == pti_pkg::OFS_IRQEN && pwdata[4:0] == 5'h00
		|-> ##2 !irqRequest) else $error("request kept");
	a_prio_set: assert property (wrDone && paddr == pti_pkg::OFS_IRQCTL
		|-> ##2 irqPriority == $past(pwdata[3:1], 2)) else $error("priority wrong");
	a_prio_read: assert property (pready && !pwrite && !pslverr && paddr == pti_pkg::OFS_IRQCTL
		|-> prdata[3:1] == irqPriority) else $error("priority read");
	a_init_level: assert property (wrDone && paddr == pti_pkg::OFS_CTRL1 && stopped && pwdata[5]
		|-> ##2 pwmOutEn && pwmOut == $past(pwdata[0], 2)) else $error("initial level");
endmodule
bind pti_timer pti_timer_props pti_timer_props_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .captureIn(captureIn), .irqAck(irqAck), .pwmOut(pwmOut),
	.pwmOutEn(pwmOutEn), .irqRequest(irqRequest), .irqPriority(irqPriority));

// File: verification/pti_irq_ctrl_model.sv
// Interrupt controller: acknowledges a request once, after ackDelay cycles; every cycle when ackDelay is 15
module pti_irq_ctrl_model (
	input  wire logic       clk,         // Clock
	input  wire logic       reset_n,     // Reset, active low
	input  wire logic       irqRequest,  // Request level
	input  wire logic [2:0] irqPriority, // Request priority
	input  wire logic [2:0] cpuLevel,    // Processor level
	input  wire logic [3:0] ackDelay,    // Answer latency
	output logic            irqAck       // Ack pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] waitCnt; // Cycles request stood
	// ack pulses only, flags left for the handler
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			waitCnt <= 4'h0;
			irqAck  <= 1'b0;
		end else begin
			irqAck  <= irqRequest && irqPriority > cpuLevel && waitCnt == ackDelay;
			waitCnt <= !irqRequest ? 4'h0 : (waitCnt != 4'hf ? waitCnt + 4'h1 : waitCnt);
		end
	end
endmodule

// File: verification/pti_timer_bench.sv
module pti_timer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;       // Clock
	logic        reset_n = 1'b0;   // Reset
	logic        psel = 1'b0;      // Bus
	logic        penable = 1'b0;   // Bus
	logic        pwrite = 1'b0;    // Bus
	logic [7:0]  paddr = 8'h00;    // Bus
	logic [31:0] pwdata = 32'h0;   // Bus
	logic        captureIn = 1'b0; // Pin
	logic [31:0] prdata;           // Bus
	logic        pready, pslverr, irqAck, pwmOut, pwmOutEn, irqRequest;
	logic [2:0]  irqPriority;      // Level
	int          bad_count = 0;    // Mismatches
	int          n_checks = 0;     // Compares
	int          acks = 0;         // Acks seen
	always #10 clk = ~clk;
	always @(posedge clk) if (irqAck === 1'b1) acks++;
	pti_timer pti_timer_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .captureIn(captureIn), .irqAck(irqAck), .pwmOut(pwmOut),
		.pwmOutEn(pwmOutEn), .irqRequest(irqRequest), .irqPriority(irqPriority));
	pti_irq_ctrl_model pti_irq_ctrl_model_inst (.clk(clk), .reset_n(reset_n), .irqRequest(irqRequest),
		.irqPriority(irqPriority), .cpuLevel(3'h0), .ackDelay(4'h2), .irqAck(irqAck));
	task automatic final_report();
		if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Idle edge first, so psel is never driven twice in one step
	task automatic apb(input logic dir, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int t;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= dir;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (t >= 50) chk(32'h0, 32'h1, "no ready");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp, m);
	endtask
	// Phase free: 5 whole periods hold 5 low spans
	task automatic low_span(input logic [31:0] exp, input string m);
		logic [31:0] lows;
		lows = 0;
		repeat (25) @(posedge clk);
		repeat (50) begin
			@(posedge clk);
			lows += {31'h0, pwmOut === 1'b0};
		end
		chk(lows, exp, m);
	endtask
	task automatic sc_reset();
		logic [31:0] q;
		logic        e;
		rd(pti_pkg::OFS_CMP_A, 32'hffff, "compare reset");
		wr(pti_pkg::OFS_COUNTER, 32'h1234);
		rd(pti_pkg::OFS_COUNTER, 32'h1234, "counter readback");
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk({q[31:1], e}, 32'h1, "unmapped read");
	endtask
	task automatic sc_pwm();
		wr(pti_pkg::OFS_CTRL1, 32'h31);
		repeat (2) @(posedge clk);
		chk({30'h0, pwmOutEn, pwmOut}, 32'h3, "initial level");
		wr(pti_pkg::OFS_CMP_A, 32'h9);
		wr(pti_pkg::OFS_CMP_B, 32'h6);
		wr(pti_pkg::OFS_CMP_C, 32'h2);
		wr(pti_pkg::OFS_COUNTER, 32'h0);
		wr(pti_pkg::OFS_MODE, 32'h9);
		low_span(32'd20, "low from c to b");
		wr(pti_pkg::OFS_MODE, 32'h0);
		wr(pti_pkg::OFS_CMP_D, 32'h8);
		wr(pti_pkg::OFS_MODE, 32'hd);
		low_span(32'd30, "low from c to d");
		wr(pti_pkg::OFS_MODE, 32'h0);
		wr(pti_pkg::OFS_CTRL2, 32'h1);
		wr(pti_pkg::OFS_MODE, 32'h9);
		repeat (30) @(posedge clk);
		rd(pti_pkg::OFS_MODE, 32'h8, "stop at period");
	endtask
	// Write timed onto the wrap edge: counter 9 at the access edge
	task automatic sc_clear();
		wr(pti_pkg::OFS_COUNTER, 32'h0);
		wr(pti_pkg::OFS_MODE, 32'h1);
		repeat (6) @(posedge clk);
		wr(pti_pkg::OFS_COUNTER, 32'h100);
		wr(pti_pkg::OFS_MODE, 32'h0);
		rd(pti_pkg::OFS_COUNTER, 32'h4, "clear beats write");
	endtask
	task automatic sc_irq();
		logic [31:0] q;
		logic        e;
		wr(pti_pkg::OFS_IRQCTL, 32'ha);
		wr(pti_pkg::OFS_IRQEN, 32'h1);
		repeat (6) @(posedge clk);
		chk({29'h0, irqPriority}, 32'h5, "priority");
		chk({30'h0, acks != 0, irqRequest}, 32'h3, "ack keeps request");
		rd(pti_pkg::OFS_IRQCTL, 32'hb, "control read");
		wr(pti_pkg::OFS_IRQEN, 32'h0);
		repeat (3) @(posedge clk);
		chk({31'h0, irqRequest}, 32'h0, "enable off");
		wr(pti_pkg::OFS_IRQEN, 32'h1f);
		repeat (3) @(posedge clk);
		chk({31'h0, irqRequest}, 32'h1, "flags kept");
		apb(1'b0, pti_pkg::OFS_STATUS, 32'h0, q, e);
		chk({29'h0, q[2:0]}, 32'h7, "sources");
		wr(pti_pkg::OFS_STATUS, 32'h0);
		wr(pti_pkg::OFS_STATUS, 32'h1f);
		repeat (3) @(posedge clk);
		chk({31'h0, irqRequest}, 32'h0, "flags cleared");
		rd(pti_pkg::OFS_STATUS, 32'h0, "one keeps zero");
	endtask
	task automatic sc_cap();
		logic [31:0] q;
		logic        e;
		wr(pti_pkg::OFS_IRQEN, 32'h8);
		wr(pti_pkg::OFS_CMP_D, 32'hffff);
		wr(pti_pkg::OFS_CTRL2, 32'h4);
		wr(pti_pkg::OFS_COUNTER, 32'h0);
		wr(pti_pkg::OFS_MODE, 32'h1);
		captureIn <= 1'b1;
		repeat (4) @(posedge clk);
		captureIn <= 1'b0;
		repeat (6) @(posedge clk);
		wr(pti_pkg::OFS_MODE, 32'h0);
		chk({31'h0, irqRequest}, 32'h1, "capture request");
		apb(1'b0, pti_pkg::OFS_CMP_D, 32'h0, q, e);
		chk(q, 32'h4, "captured count");
	endtask
	// Divide by 32: 74 run edges hold two ticks
	task automatic sc_src();
		wr(pti_pkg::OFS_CTRL1, 32'h29);
		repeat (2) @(posedge clk);
		wr(pti_pkg::OFS_COUNTER, 32'h0);
		wr(pti_pkg::OFS_MODE, 32'h1);
		repeat (70) @(posedge clk);
		wr(pti_pkg::OFS_MODE, 32'h0);
		rd(pti_pkg::OFS_COUNTER, 32'h2, "slow source count");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		sc_reset();
		sc_pwm();
		sc_clear();
		sc_irq();
		sc_cap();
		sc_src();
		final_report();
	end
	initial begin
		#100us;
		bad_count++;
		final_report();
	end
endmodule
